// file: pkg/shst_pkg.sv
// constants, field layout and helpers of the homing and status terminal block
// assumes a 32-bit classic wishbone slave with byte addresses on 8 bits
package shst_pkg;
	// terminal function codes
	localparam logic [7:0] SHST_FN_HOMING_TRIGGER = 8'h27;
	localparam logic [7:0] SHST_FN_HOME_SENSOR    = 8'h28;
	localparam logic [7:0] SHST_FN_READY          = 8'h01;
	localparam logic [7:0] SHST_FN_POSITION_DONE  = 8'h02;
	localparam logic [7:0] SHST_FN_SPEED_AGREE    = 8'h03;
	localparam logic [7:0] SHST_FN_MOTOR_TURNING  = 8'h04;
	localparam int         SHST_TERMINALS         = 4;
	localparam int         SHST_CODE_W            = 8;

	// register byte offsets
	localparam logic [7:0] SHST_REG_CTRL         = 8'h00;
	localparam logic [7:0] SHST_REG_IN_FUNC      = 8'h04;
	localparam logic [7:0] SHST_REG_OUT_FUNC     = 8'h08;
	localparam logic [7:0] SHST_REG_STATUS       = 8'h0c;
	localparam logic [7:0] SHST_REG_POS_THR      = 8'h10;
	localparam logic [7:0] SHST_REG_SPEED_THR    = 8'h14;
	localparam logic [7:0] SHST_REG_ROT_THR      = 8'h18;
	localparam logic [7:0] SHST_REG_IRQ_STATUS   = 8'h1c;
	localparam logic [7:0] SHST_REG_IRQ_MASK     = 8'h20;

	// control fields
	localparam int         SHST_CTRL_MODE_LSB    = 0;
	localparam int         SHST_CTRL_EDGE_BIT    = 2;
	localparam logic [1:0] SHST_MODE_POSITION    = 2'h0;
	localparam logic [1:0] SHST_MODE_SPEED       = 2'h1;
	localparam logic [1:0] SHST_MODE_TORQUE      = 2'h2;

	// status fields
	localparam int         SHST_ST_READY_BIT     = 0;
	localparam int         SHST_ST_POS_DONE_BIT  = 1;
	localparam int         SHST_ST_SPEED_BIT     = 2;
	localparam int         SHST_ST_TURNING_BIT   = 3;
	localparam int         SHST_ST_RETURN_BIT    = 4;
	localparam int         SHST_ST_OUT_LSB       = 8;

	// interrupt bits
	localparam int         SHST_IRQ_W            = 3;
	localparam int         SHST_IRQ_HOME_CMD     = 0;
	localparam int         SHST_IRQ_HOME_HIT     = 1;
	localparam int         SHST_IRQ_POS_DONE     = 2;

	// reset values
	localparam logic [1:0]  SHST_MODE_RESET      = 2'h0;
	localparam logic        SHST_EDGE_RESET      = 1'b1;
	localparam logic [31:0] SHST_IN_FUNC_RESET   = 32'h0000_2827;
	localparam logic [31:0] SHST_OUT_FUNC_RESET  = 32'h0403_0201;
	localparam logic [31:0] SHST_POS_THR_RESET   = 32'h0000_000a;
	localparam logic [31:0] SHST_SPEED_THR_RESET = 32'h0000_000a;
	localparam logic [31:0] SHST_ROT_THR_RESET   = 32'h0000_0014;

	typedef enum logic [0:0] {
		SHST_HOME_IDLE   = 1'b0,
		SHST_HOME_RETURN = 1'b1
	} shst_home_type;

	// magnitude of a - b without overflow
	function automatic logic [32:0] shst_abs_diff(input logic [31:0] a, input logic [31:0] b);
		logic signed [32:0] d;
		d = $signed({a[31], a}) - $signed({b[31], b});
		return d[32] ? 33'(-d) : 33'(d);
	endfunction : shst_abs_diff

	// which terminals carry a given function code
	function automatic logic [3:0] shst_match(input logic [31:0] func, input logic [7:0] code);
		logic [3:0] m;
		m = 4'h0;
		for (int k = 0; k < SHST_TERMINALS; k++) begin
			m[k] = (func[k*SHST_CODE_W +: SHST_CODE_W] == code);
		end
		return m;
	endfunction : shst_match

	// byte-lane write merge
	function automatic logic [31:0] shst_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (sel[k]) begin
				r[k*8 +: 8] = wd[k*8 +: 8];
			end
		end
		return r;
	endfunction : shst_merge
endpackage : shst_pkg

// file: core/shst_edge.sv
// rising-edge detector for one terminal level
// assumes the level is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module shst_edge
	import shst_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// level in, edge out
	input  wire logic level_i,
	output logic      rise_o
);
	typedef struct packed {
		logic prev;
	} shst_edge_state_type;

	shst_edge_state_type state;
	shst_edge_state_type next_state;

	always_comb begin
		next_state      = state;
		next_state.prev = level_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	assign rise_o = level_i & ~state.prev;
endmodule : shst_edge
`default_nettype wire

// file: core/shst_compare.sv
// threshold window check: |a - b| <= threshold
// assumes two's complement inputs; purely combinational
`timescale 1ns/1ps
`default_nettype none
module shst_compare
	import shst_pkg::*;
(
	// operands
	input  wire logic [31:0] a_i,
	input  wire logic [31:0] b_i,
	input  wire logic [31:0] thr_i,
	// result
	output logic             within_o
);
	// equal to threshold counts as within
	assign within_o = shst_abs_diff(a_i, b_i) <= {1'b0, thr_i};
endmodule : shst_compare
`default_nettype wire

// file: core/shst_top.sv
// homing inputs and status outputs of the servo terminal logic
// assumes a classic wishbone master and live drive quantities sampled on clk_i
// Functional notes
// - homing trigger code loads home return command, in position mode only
// - home sensor code rising edge ends return
// - ready output on only when ready, no fault
// - position done while in position mode and deviation within threshold
// - speed agree while speed error within threshold
// - motor turning while speed above threshold
`timescale 1ns/1ps
`default_nettype none
module shst_top
	import shst_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// terminals
	input  wire logic [3:0]  term_in_i,
	output logic      [3:0]  term_out_o,
	// drive state
	input  wire logic        drive_ready_i,
	input  wire logic        drive_fault_i,
	input  wire logic [31:0] position_deviation_i,
	input  wire logic [31:0] feedback_speed_i,
	input  wire logic [31:0] command_speed_i,
	// controller side
	output logic             home_return_cmd_o,
	output logic             home_reached_o,
	output logic             homing_active_o,
	output logic             irq_o
);
	typedef struct packed {
		logic                  ack;
		logic [31:0]           dat;
		logic [1:0]            mode;
		logic                  trig_edge;
		logic [31:0]           in_func;
		logic [31:0]           out_func;
		logic [31:0]           pos_thr;
		logic [31:0]           speed_thr;
		logic [31:0]           rot_thr;
		logic [SHST_IRQ_W-1:0] irq_status;
		logic [SHST_IRQ_W-1:0] irq_mask;
		shst_home_type         home;
		logic                  home_cmd;
		logic                  home_hit;
		logic [3:0]            term_out;
		logic                  pos_done_q;
		logic                  irq;
	} shst_state_type;

	shst_state_type state;
	shst_state_type next_state;

	logic                  position_mode;
	logic                  trigger_level;
	logic                  trigger_rise;
	logic                  sensor_level;
	logic                  sensor_rise;
	logic                  ready_on;
	logic                  pos_within;
	logic                  pos_done_on;
	logic                  speed_agree_on;
	logic                  turning_on;
	logic [3:0]            term_val;
	logic [31:0]           status_word;
	logic                  bus_req;
	logic                  bus_wr;
	logic [SHST_IRQ_W-1:0] irq_event;

	// return in progress, shown in the status word and on its own output
	function automatic logic shst_returning(input shst_home_type h);
		return h == SHST_HOME_RETURN;
	endfunction : shst_returning

	assign position_mode = (state.mode == SHST_MODE_POSITION);
	assign trigger_level = |(term_in_i & shst_match(state.in_func, SHST_FN_HOMING_TRIGGER));
	assign sensor_level  = |(term_in_i & shst_match(state.in_func, SHST_FN_HOME_SENSOR));

	shst_edge u_trigger_edge (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.level_i (trigger_level),
		.rise_o  (trigger_rise)
	);

	shst_edge u_sensor_edge (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.level_i (sensor_level),
		.rise_o  (sensor_rise)
	);

	shst_compare u_pos_cmp (
		.a_i      (position_deviation_i),
		.b_i      (32'h0000_0000),
		.thr_i    (state.pos_thr),
		.within_o (pos_within)
	);

	shst_compare u_speed_cmp (
		.a_i      (feedback_speed_i),
		.b_i      (command_speed_i),
		.thr_i    (state.speed_thr),
		.within_o (speed_agree_on)
	);

	assign ready_on    = drive_ready_i & ~drive_fault_i;
	assign pos_done_on = position_mode & pos_within;
	// a speed equal to the threshold is not yet turning
	assign turning_on  = shst_abs_diff(feedback_speed_i, 32'h0000_0000) >
		{1'b0, state.rot_thr};

	// per-terminal function select, re-evaluated every cycle
	always_comb begin
		term_val = 4'h0;
		for (int k = 0; k < SHST_TERMINALS; k++) begin
			unique case (state.out_func[k*SHST_CODE_W +: SHST_CODE_W])
				SHST_FN_READY:         term_val[k] = ready_on;
				SHST_FN_POSITION_DONE: term_val[k] = pos_done_on;
				SHST_FN_SPEED_AGREE:   term_val[k] = speed_agree_on;
				SHST_FN_MOTOR_TURNING: term_val[k] = turning_on;
				default:               term_val[k] = 1'b0;
			endcase
		end
	end

	always_comb begin
		status_word                      = 32'h0000_0000;
		status_word[SHST_ST_READY_BIT]   = ready_on;
		status_word[SHST_ST_POS_DONE_BIT] = pos_done_on;
		status_word[SHST_ST_SPEED_BIT]   = speed_agree_on;
		status_word[SHST_ST_TURNING_BIT] = turning_on;
		status_word[SHST_ST_RETURN_BIT]  = shst_returning(state.home);
		status_word[SHST_ST_OUT_LSB +: 4] = state.term_out;
	end

	assign bus_req = wb_cyc_i & wb_stb_i & ~state.ack;
	assign bus_wr  = bus_req & wb_we_i;

	always_comb begin
		next_state          = state;
		next_state.home_cmd = 1'b0;
		next_state.home_hit = 1'b0;
		irq_event           = '0;

		// homing sequence, only in position mode
		unique case (state.home)
			SHST_HOME_IDLE: begin
				if (position_mode && (state.trig_edge ? trigger_rise : trigger_level)) begin
					next_state.home_cmd = 1'b1;
					next_state.home     = SHST_HOME_RETURN;
				end
			end
			SHST_HOME_RETURN: begin
				// triggers here are dropped, not queued; leaving position aborts
				if (!position_mode) begin
					next_state.home = SHST_HOME_IDLE;
				end else if (sensor_rise) begin
					next_state.home_hit = 1'b1;
					next_state.home     = SHST_HOME_IDLE;
				end
			end
		endcase

		next_state.term_out   = term_val;
		next_state.pos_done_q = pos_done_on;

		irq_event[SHST_IRQ_HOME_CMD] = next_state.home_cmd;
		irq_event[SHST_IRQ_HOME_HIT] = next_state.home_hit;
		irq_event[SHST_IRQ_POS_DONE] = pos_done_on & ~state.pos_done_q;

		// bus: one-cycle registered answer, ack dropped the cycle after
		next_state.ack = bus_req;
		next_state.dat = 32'h0000_0000;
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				SHST_REG_CTRL: begin
					next_state.dat[SHST_CTRL_MODE_LSB +: 2] = state.mode;
					next_state.dat[SHST_CTRL_EDGE_BIT]      = state.trig_edge;
				end
				SHST_REG_IN_FUNC:    next_state.dat = state.in_func;
				SHST_REG_OUT_FUNC:   next_state.dat = state.out_func;
				SHST_REG_STATUS:     next_state.dat = status_word;
				SHST_REG_POS_THR:    next_state.dat = state.pos_thr;
				SHST_REG_SPEED_THR:  next_state.dat = state.speed_thr;
				SHST_REG_ROT_THR:    next_state.dat = state.rot_thr;
				SHST_REG_IRQ_STATUS: next_state.dat[SHST_IRQ_W-1:0] = state.irq_status;
				SHST_REG_IRQ_MASK:   next_state.dat[SHST_IRQ_W-1:0] = state.irq_mask;
				default:             next_state.dat = 32'h0000_0000;
			endcase
		end

		next_state.irq_status = state.irq_status | irq_event;
		if (bus_wr) begin
			unique case (wb_adr_i)
				SHST_REG_CTRL: begin
					if (wb_sel_i[0]) begin
						next_state.mode      = wb_dat_i[SHST_CTRL_MODE_LSB +: 2];
						next_state.trig_edge = wb_dat_i[SHST_CTRL_EDGE_BIT];
					end
				end
				SHST_REG_IN_FUNC: begin
					next_state.in_func = shst_merge(state.in_func, wb_dat_i, wb_sel_i);
				end
				SHST_REG_OUT_FUNC: begin
					next_state.out_func = shst_merge(state.out_func, wb_dat_i, wb_sel_i);
				end
				SHST_REG_POS_THR: begin
					next_state.pos_thr = shst_merge(state.pos_thr, wb_dat_i, wb_sel_i);
				end
				SHST_REG_SPEED_THR: begin
					next_state.speed_thr = shst_merge(state.speed_thr, wb_dat_i, wb_sel_i);
				end
				SHST_REG_ROT_THR: begin
					next_state.rot_thr = shst_merge(state.rot_thr, wb_dat_i, wb_sel_i);
				end
				SHST_REG_IRQ_STATUS: begin
					// write one clears; a new event in the same cycle wins
					if (wb_sel_i[0]) begin
						next_state.irq_status = (state.irq_status & ~wb_dat_i[SHST_IRQ_W-1:0])
							| irq_event;
					end
				end
				SHST_REG_IRQ_MASK: begin
					if (wb_sel_i[0]) begin
						next_state.irq_mask = wb_dat_i[SHST_IRQ_W-1:0];
					end
				end
				default: begin
					next_state.mode = state.mode;
				end
			endcase
		end

		next_state.irq = |(next_state.irq_status & next_state.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state           <= '0;
			state.mode      <= SHST_MODE_RESET;
			state.trig_edge <= SHST_EDGE_RESET;
			state.in_func   <= SHST_IN_FUNC_RESET;
			state.out_func  <= SHST_OUT_FUNC_RESET;
			state.pos_thr   <= SHST_POS_THR_RESET;
			state.speed_thr <= SHST_SPEED_THR_RESET;
			state.rot_thr   <= SHST_ROT_THR_RESET;
			state.home      <= SHST_HOME_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	assign wb_dat_o          = state.dat;
	assign wb_ack_o          = state.ack;
	assign term_out_o        = state.term_out;
	assign home_return_cmd_o = state.home_cmd;
	assign home_reached_o    = state.home_hit;
	assign homing_active_o   = shst_returning(state.home);
	assign irq_o             = state.irq;
endmodule : shst_top
`default_nettype wire

// file: verification/shst_host_model.sv
// host controller and home sensor model on the input terminals
// assumes go_i and dly_i come from the bench, active_i from the block
`timescale 1ns/1ps
`default_nettype none
module shst_host_model
	import shst_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bench control
	input  wire logic       go_i,
	input  wire logic [3:0] dly_i,
	// block side
	input  wire logic       active_i,
	output logic      [3:0] term_o
);
	logic [3:0] cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i || !active_i) begin
			cnt       <= 4'h0;
			term_o[1] <= 1'b0;
		end else if (cnt == dly_i) begin
			term_o[1] <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
		term_o[0]   <= go_i && !rst_i;
		term_o[3:2] <= 2'h0;
	end
endmodule : shst_host_model
`default_nettype wire

// file: verification/shst_monitor.sv
// checker on the ports of shst_top
// assumes reset terminal functions and thresholds stay in force
`timescale 1ns/1ps
`default_nettype none
module shst_monitor
	import shst_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic [3:0]  term_in_i,
	input wire logic [3:0]  term_out_o,
	input wire logic        drive_ready_i,
	input wire logic        drive_fault_i,
	input wire logic [31:0] feedback_speed_i,
	input wire logic [31:0] command_speed_i,
	input wire logic        home_return_cmd_o,
	input wire logic        home_reached_o,
	input wire logic        homing_active_o,
	input wire logic        irq_o
);
	logic [1:0]  age;
	logic [32:0] sd;
	logic [32:0] se;
	logic [32:0] sa;
	logic [32:0] fa;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	// outputs are live from the second running edge after reset or a freeze
	always_ff @(posedge clk_i) begin
		age <= (rst_i || !ce_i) ? 2'h0 : (age == 2'h2 ? age : age + 2'h1);
	end

	always_comb begin
		sd = {feedback_speed_i[31], feedback_speed_i} - {command_speed_i[31], command_speed_i};
		se = {feedback_speed_i[31], feedback_speed_i};
		sa = sd[32] ? -sd : sd;
		fa = se[32] ? -se : se;
	end

	a_ready_follow: assert property (age == 2'h2 |->
		term_out_o[0] == $past(drive_ready_i && !drive_fault_i)) else $error("ready out wrong");
	a_speed_agree: assert property (age == 2'h2 |->
		term_out_o[2] == ($past(sa) <= {1'b0, SHST_SPEED_THR_RESET}))
		else $error("speed agree wrong");
	a_motor_turning: assert property (age == 2'h2 |->
		term_out_o[3] == ($past(fa) > {1'b0, SHST_ROT_THR_RESET}))
		else $error("turning out wrong");
	a_cmd_pulse: assert property (home_return_cmd_o |=> !home_return_cmd_o)
		else $error("command pulse too long");
	a_cmd_active: assert property (home_return_cmd_o |-> homing_active_o)
		else $error("command without return");
	a_cmd_idle: assert property (home_return_cmd_o |-> !$past(homing_active_o))
		else $error("command while returning");
	a_reach_drop: assert property (home_reached_o |->
		!homing_active_o && $past(homing_active_o)) else $error("reached not ending return");
	a_reach_edge: assert property (home_reached_o |->
		$past(term_in_i[1]) && !$past(term_in_i[1], 2)) else $error("reached without edge");

	c_cmd: cover property (home_return_cmd_o);
	c_reach: cover property (home_reached_o);
	c_irq: cover property (irq_o);
endmodule : shst_monitor

bind shst_top shst_monitor i_mon (.clk_i, .rst_i, .ce_i, .term_in_i, .term_out_o, .drive_ready_i,
	.drive_fault_i, .feedback_speed_i, .command_speed_i, .home_return_cmd_o,
	.home_reached_o, .homing_active_o, .irq_o);
`default_nettype wire

// file: verification/shst_bench.sv
// self-checking bench of the homing and status terminal block
// assumes the host model drives the input terminals
`timescale 1ns/1ps
`default_nettype none
module shst_bench;
	import shst_pkg::*;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        we    = 1'b0;
	logic        rdy   = 1'b0;
	logic        flt   = 1'b0;
	logic        go    = 1'b0;
	logic        ce    = 1'b1;
	logic [31:0] rq;
	logic [7:0]  adr   = 8'h00;
	logic [31:0] wdat  = 32'h0;
	logic [31:0] dev   = 32'h0;
	logic [31:0] fb    = 32'h0;
	logic [31:0] cmd   = 32'h0;
	logic [3:0]  dly   = 4'h0;
	logic [3:0]  tin;
	logic [3:0]  tout;
	logic [31:0] rdat;
	logic        ack;
	logic        hcmd;
	logic        hrch;
	logic        hact;
	logic        irq;
	int          bad_count = 0;
	int          n_checks  = 0;

	shst_top i_dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .term_in_i(tin), .term_out_o(tout), .drive_ready_i(rdy),
		.drive_fault_i(flt), .position_deviation_i(dev), .feedback_speed_i(fb),
		.command_speed_i(cmd), .home_return_cmd_o(hcmd), .home_reached_o(hrch),
		.homing_active_o(hact), .irq_o(irq));

	shst_host_model i_host (.clk_i, .rst_i, .go_i(go), .dly_i(dly), .active_i(hact),
		.term_o(tin));

	always #50 clk_i = ~clk_i;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		// read data stands only in the ack cycle
		rq = rdat;
		check("bus ack", 32'(ack), 32'h1);
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(nm, rq, exp);
	endtask : rd

	task automatic t_regs;
		rd("ctrl", SHST_REG_CTRL, 32'h4);
		rd("in func", SHST_REG_IN_FUNC, SHST_IN_FUNC_RESET);
		rd("out func", SHST_REG_OUT_FUNC, SHST_OUT_FUNC_RESET);
		rd("rot thr", SHST_REG_ROT_THR, SHST_ROT_THR_RESET);
		bus(1'b1, 8'h40, 32'hffff_ffff);
		rd("unmapped", 8'h40, 32'h0);
	endtask : t_regs

	task automatic t_ready;
		for (int k = 0; k < 4; k++) begin
			rdy <= k[0];
			flt <= k[1];
			repeat (2) @(posedge clk_i);
			check("ready out", 32'(tout[0]), 32'(k == 1));
		end
		rdy <= 1'b1;
		flt <= 1'b0;
	endtask : t_ready

	// a low enable freezes the outputs
	task automatic t_hold;
		@(posedge clk_i);
		ce  <= 1'b0;
		rdy <= 1'b0;
		repeat (3) @(posedge clk_i);
		check("frozen", 32'(tout[0]), 32'h1);
		ce  <= 1'b1;
		repeat (2) @(posedge clk_i);
		check("thawed", 32'(tout[0]), 32'h0);
		rdy <= 1'b1;
	endtask : t_hold

	task automatic drv(input logic [31:0] d, f, c, input logic [3:0] exp);
		dev <= d;
		fb  <= f;
		cmd <= c;
		repeat (2) @(posedge clk_i);
		check("term out", 32'(tout), 32'(exp));
	endtask : drv

	// equal to threshold is inside for done and agree, not turning
	task automatic t_thr;
		drv(32'ha, 32'h14, 32'ha, 4'h7);
		drv(32'hffff_fff5, 32'hffff_ffeb, 32'hffff_fff6, 4'h9);
		drv(32'hffff_fff6, 32'h15, 32'h1f, 4'hf);
		bus(1'b1, SHST_REG_POS_THR, 32'hb);
		drv(32'hffff_fff5, 32'h15, 32'h1f, 4'hf);
	endtask : t_thr

	task automatic t_home(input logic [3:0] d);
		int n;
		dly <= d;
		go  <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hcmd !== 1'b1 && n < 10);
		check("cmd pulse", 32'(hcmd), 32'h1);
		check("active", 32'(hact), 32'h1);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hrch !== 1'b1 && n < 40);
		check("reached", 32'(hrch), 32'h1);
		check("active off", 32'(hact), 32'h0);
	endtask : t_home

	task automatic t_irq;
		bus(1'b1, SHST_REG_IRQ_MASK, 32'h7);
		t_home(4'h0);
		check("irq on", 32'(irq), 32'h1);
		rd("irq st", SHST_REG_IRQ_STATUS, 32'h7);
		bus(1'b1, SHST_REG_IRQ_STATUS, 32'h7);
		rd("irq clr", SHST_REG_IRQ_STATUS, 32'h0);
		bus(1'b1, SHST_REG_IRQ_MASK, 32'h0);
		t_home(4'hf);
		check("irq masked", 32'(irq), 32'h0);
		rd("irq st2", SHST_REG_IRQ_STATUS, 32'h3);
	endtask : t_irq

	// speed mode: trigger ignored, done off; level mode takes a held trigger
	task automatic t_refuse;
		bus(1'b1, SHST_REG_CTRL, 32'h5);
		go <= 1'b1;
		repeat (8) @(posedge clk_i);
		check("refused", 32'(hact), 32'h0);
		drv(32'h0, 32'h0, 32'h0, 4'h5);
		rd("status", SHST_REG_STATUS, 32'h505);
		bus(1'b1, SHST_REG_CTRL, 32'h0);
		check("level trig", 32'(hact), 32'h1);
		go <= 1'b0;
		bus(1'b1, SHST_REG_CTRL, 32'h5);
		check("abort", 32'(hact), 32'h0);
	endtask : t_refuse

	task automatic wrap_up;
		if (bad_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#(100 * 5000);
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_ready();
		t_hold();
		t_thr();
		t_irq();
		t_refuse();
		wrap_up();
	end
endmodule : shst_bench
`default_nettype wire
